// ### design/rbirq_top.sv
// Receive byte path control, event flags and interrupt pin logic, with its word FIFO
// Operation
// - Codes 11/10 drive high/low, else float
// - Codes 01/00 drive actively, true or inverted
// - Byte mode bit selects byte or bit-serial
// - Gap length sets invalid bit times
// - Gap counting starts after a valid bit
// - End of frame moves partial byte out
// - Length zero flags first invalid bit
// - Enable bits per event, both channels
// - Reading empty data register flags underflow
// - Loading unread data register flags overflow
// - Loading data register raises full flag
// - End-of-frame flag cleared by status read
// - Status flags set regardless of enables
// - Status reads zero outside receive mode
// - All-valid flag never raises interrupt
`timescale 1ns/1ps
`include "rbirq_regs.svh"

module rbirq_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= next_ptr(wr_q);
            end
            if (pop) begin
                rd_q <= next_ptr(rd_q);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module rbirq_top #(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       spi_ss_n,
    input  wire logic       spi_sck,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    output logic            spi_miso_oe,
    input  wire logic       rx_mode,
    input  wire logic [1:0] rx_bit_strobe,
    input  wire logic [1:0] rx_bit_valid,
    input  wire logic [1:0] rx_bit_value,
    output logic            irq_out,
    output logic            irq_oe,
    output logic            serial_data_pin,
    output logic            serial_data_valid_pin
);
    logic [1:0] ss_s;
    logic [2:0] sck_s;
    logic [1:0] mosi_s;
    rbirq_pkg::rbirq_spi_state_type spi_state_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] shin_q;
    logic       wr_q;
    logic [5:0] addr_q;
    logic [7:0] shout_q;
    logic       sck_rise;
    logic       sck_fall;
    logic [7:0] in_byte;
    logic       addr_done;
    logic       rd_stb;
    logic       wr_stb;

    logic [1:0] pin_cfg_q;
    logic       byte_mode_q;
    logic [2:0] eof_len_q;
    logic [7:0] irq_en_q;

    logic [1:0] full_q, eof_q, under_q, over_q, valid_q, dfull_q;
    logic [7:0] dreg_q [2];
    logic [1:0] armed_q, pend_q;
    logic [2:0] gap_q [2];
    logic [7:0] sh_q [2];
    logic [3:0] nb_q [2];
    rbirq_pkg::rbirq_word_type pend_w_q [2];
    logic [1:0] eof_ev;
    logic [1:0] valid_bit;
    logic [1:0] pop_c;
    logic [1:0] rd_data_c;
    logic       rd_status;
    logic [7:0] status_byte;
    logic [7:0] rd_word;
    logic       irq_act;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic       fifo_out_ready;
    rbirq_pkg::rbirq_word_type fifo_in_w;
    rbirq_pkg::rbirq_word_type fifo_out_w;

    // Pin synchronisers; stage 0 feeds stage 1 only
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ss_s   <= 2'h3;
            sck_s  <= 3'h0;
            mosi_s <= 2'h0;
        end else begin
            ss_s   <= {ss_s[0], spi_ss_n};
            sck_s  <= {sck_s[1:0], spi_sck};
            mosi_s <= {mosi_s[0], spi_mosi};
        end
    end

    assign sck_rise  = sck_s[1] & ~sck_s[2];
    assign sck_fall  = ~sck_s[1] & sck_s[2];
    assign in_byte   = {shin_q, mosi_s[1]};
    assign addr_done = (spi_state_q == rbirq_pkg::SPI_ADDR) && sck_rise && (bit_cnt_q == 3'h7);
    assign rd_stb    = addr_done && !in_byte[`RBIRQ_BIT_SPI_WRITE];
    assign wr_stb    = (spi_state_q == rbirq_pkg::SPI_DATA) && sck_rise && (bit_cnt_q == 3'h7) && wr_q;
    assign rd_status = rd_stb && (in_byte[5:0] == `RBIRQ_OFS_STATUS);
    assign rd_data_c = {rd_stb && (in_byte[5:0] == `RBIRQ_OFS_DATA_B),
                        rd_stb && (in_byte[5:0] == `RBIRQ_OFS_DATA_A)};

    // Status hidden outside receive mode; all-valid bits are status only
    assign status_byte = rx_mode ? {valid_q[1], under_q[1] | over_q[1], eof_q[1], full_q[1],
                                    valid_q[0], under_q[0] | over_q[0], eof_q[0], full_q[0]} : 8'h00;

    function automatic logic [7:0] read_mux(input logic [5:0] a);
        case (a)
            `RBIRQ_OFS_PIN_CFG:  read_mux = {6'h00, pin_cfg_q};
            `RBIRQ_OFS_BYTE_CTL: read_mux = {4'h0, byte_mode_q, eof_len_q};
            `RBIRQ_OFS_IRQ_EN:   read_mux = irq_en_q;
            `RBIRQ_OFS_STATUS:   read_mux = status_byte;
            `RBIRQ_OFS_DATA_A:   read_mux = dreg_q[0];
            `RBIRQ_OFS_DATA_B:   read_mux = dreg_q[1];
            default:             read_mux = 8'h00;
        endcase
    endfunction

    assign rd_word = read_mux(in_byte[5:0]);

    // Serial register port: address byte then one data byte, mode 0
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            spi_state_q <= rbirq_pkg::SPI_IDLE;
            bit_cnt_q   <= 3'h0;
            shin_q      <= 7'h00;
            wr_q        <= 1'b0;
            addr_q      <= 6'h00;
        end else if (ss_s[1]) begin
            spi_state_q <= rbirq_pkg::SPI_IDLE;
            bit_cnt_q   <= 3'h0;
        end else begin
            if (sck_rise) begin
                shin_q    <= in_byte[6:0];
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            case (spi_state_q)
                rbirq_pkg::SPI_IDLE: begin
                    spi_state_q <= rbirq_pkg::SPI_ADDR;
                end
                rbirq_pkg::SPI_ADDR: begin
                    if (addr_done) begin
                        wr_q        <= in_byte[`RBIRQ_BIT_SPI_WRITE];
                        addr_q      <= in_byte[5:0];
                        spi_state_q <= rbirq_pkg::SPI_DATA;
                    end
                end
                rbirq_pkg::SPI_DATA: begin
                    if (sck_rise && bit_cnt_q == 3'h7) begin
                        spi_state_q <= rbirq_pkg::SPI_DONE;
                    end
                end
                rbirq_pkg::SPI_DONE: begin
                    spi_state_q <= rbirq_pkg::SPI_DONE;
                end
                default: begin
                    spi_state_q <= rbirq_pkg::SPI_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            shout_q     <= 8'h00;
            spi_miso    <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            if (rd_stb) begin
                shout_q  <= {rd_word[6:0], 1'b0};
                spi_miso <= rd_word[7];
            end else if (sck_fall && spi_state_q == rbirq_pkg::SPI_DATA) begin
                shout_q  <= {shout_q[6:0], 1'b0};
                spi_miso <= shout_q[7];
            end
            spi_miso_oe <= !ss_s[1] && (rd_stb || (spi_miso_oe && spi_state_q == rbirq_pkg::SPI_DATA));
        end
    end

    // Control registers; reserved bits are not stored
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pin_cfg_q   <= `RBIRQ_RST_PIN_CFG;
            byte_mode_q <= `RBIRQ_RST_BYTE_MODE;
            eof_len_q   <= `RBIRQ_RST_EOF_LEN;
            irq_en_q    <= `RBIRQ_RST_IRQ_EN;
        end else if (wr_stb) begin
            case (addr_q)
                `RBIRQ_OFS_PIN_CFG:  pin_cfg_q <= in_byte[1:0];
                `RBIRQ_OFS_BYTE_CTL: begin
                    byte_mode_q <= in_byte[`RBIRQ_BIT_BYTE_MODE];
                    eof_len_q   <= in_byte[2:0];
                end
                `RBIRQ_OFS_IRQ_EN:   irq_en_q <= in_byte;
                default:             irq_en_q <= irq_en_q;
            endcase
        end
    end

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            valid_bit[c] = rx_mode && rx_bit_strobe[c] && rx_bit_valid[c];
            eof_ev[c]    = rx_mode && rx_bit_strobe[c] && !rx_bit_valid[c] && armed_q[c]
                           && (gap_q[c] == eof_len_q);
            pop_c[c]     = fifo_out_valid && fifo_out_ready && (fifo_out_w.chan == c[0]);
        end
    end

    // Gap counting and byte assembly per channel
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            armed_q <= 2'h0;
            pend_q  <= 2'h0;
            for (int c = 0; c < 2; c++) begin
                gap_q[c]    <= 3'h0;
                sh_q[c]     <= 8'h00;
                nb_q[c]     <= 4'h0;
                pend_w_q[c] <= '0;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (fifo_in_ready && (c == 0 ? pend_q[0] : !pend_q[0])) begin
                    pend_q[c] <= 1'b0;
                end
                if (!rx_mode) begin
                    armed_q[c] <= 1'b0;
                    nb_q[c]    <= 4'h0;
                end else if (valid_bit[c]) begin
                    armed_q[c] <= 1'b1;
                    gap_q[c]   <= 3'h0;
                    if (byte_mode_q) begin
                        sh_q[c] <= {sh_q[c][6:0], rx_bit_value[c]};
                        nb_q[c] <= (nb_q[c] == 4'h7) ? 4'h0 : nb_q[c] + 4'h1;
                        if (nb_q[c] == 4'h7) begin
                            pend_q[c]   <= 1'b1;
                            pend_w_q[c] <= '{chan: c[0], all_valid: 1'b1, data: {sh_q[c][6:0], rx_bit_value[c]}};
                        end
                    end
                end else if (eof_ev[c]) begin
                    armed_q[c] <= 1'b0;
                    nb_q[c]    <= 4'h0;
                    if (byte_mode_q && nb_q[c] != 4'h0) begin
                        pend_q[c]   <= 1'b1;
                        pend_w_q[c] <= '{chan: c[0], all_valid: 1'b0, data: sh_q[c]};
                    end
                end else if (rx_bit_strobe[c] && armed_q[c]) begin
                    gap_q[c] <= gap_q[c] + 3'h1;
                end
            end
        end
    end

    assign fifo_in_w      = pend_q[0] ? pend_w_q[0] : pend_w_q[1];
    // Hold data registers steady while the host shifts a byte
    assign fifo_out_ready = (spi_state_q != rbirq_pkg::SPI_DATA);

    rbirq_fifo #(
        .WIDTH ($bits(rbirq_pkg::rbirq_word_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .in_valid  (|pend_q),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_w),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_w)
    );

    // Event flags; a set in the clearing cycle wins
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            full_q  <= 2'h0;
            eof_q   <= 2'h0;
            under_q <= 2'h0;
            over_q  <= 2'h0;
            valid_q <= 2'h0;
            dfull_q <= 2'h0;
            dreg_q  <= '{8'h00, 8'h00};
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (rd_status) begin
                    full_q[c]  <= 1'b0;
                    eof_q[c]   <= 1'b0;
                    under_q[c] <= 1'b0;
                    over_q[c]  <= 1'b0;
                end
                if (rd_data_c[c]) begin
                    dfull_q[c] <= 1'b0;
                    if (!dfull_q[c]) begin
                        under_q[c] <= 1'b1;
                    end
                end
                if (eof_ev[c]) begin
                    eof_q[c] <= 1'b1;
                end
                if (pop_c[c]) begin
                    dreg_q[c]  <= fifo_out_w.data;
                    valid_q[c] <= fifo_out_w.all_valid;
                    dfull_q[c] <= 1'b1;
                    full_q[c]  <= 1'b1;
                    if (dfull_q[c] && !rd_data_c[c]) begin
                        over_q[c] <= 1'b1;
                    end
                end
            end
        end
    end

    // Enable order per channel: underflow, overflow, end of frame, full
    assign irq_act = rx_mode && |({under_q[1], over_q[1], eof_q[1], full_q[1],
                                   under_q[0], over_q[0], eof_q[0], full_q[0]} & irq_en_q);

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            irq_out <= 1'b0;
            irq_oe  <= 1'b1;
        end else begin
            case (pin_cfg_q)
                `RBIRQ_PIN_OPEN_SRC: begin
                    irq_out <= 1'b1;
                    irq_oe  <= irq_act;
                end
                `RBIRQ_PIN_OPEN_DRN: begin
                    irq_out <= 1'b0;
                    irq_oe  <= irq_act;
                end
                `RBIRQ_PIN_CMOS: begin
                    irq_out <= irq_act;
                    irq_oe  <= 1'b1;
                end
                default: begin
                    irq_out <= !irq_act;
                    irq_oe  <= 1'b1;
                end
            endcase
        end
    end

    // Bit-serial path for channel A when byte mode is off
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            serial_data_pin       <= 1'b0;
            serial_data_valid_pin <= 1'b0;
        end else if (!byte_mode_q && rx_bit_strobe[0]) begin
            serial_data_pin       <= rx_bit_value[0];
            serial_data_valid_pin <= rx_bit_valid[0] && rx_mode;
        end
    end

    open_source_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (irq_act && pin_cfg_q == 2'h3) |=> (irq_out && irq_oe)) else $error("open source pin not driven high");
    open_drain_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!irq_act && pin_cfg_q == 2'h2) |=> !irq_oe) else $error("open drain pin not released");
    cmos_inverted_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!irq_act && pin_cfg_q == 2'h0) |=> (irq_out && irq_oe)) else $error("inverted pin not high when idle");
    cmos_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (pin_cfg_q == 2'h1 && $stable(pin_cfg_q)) |-> (irq_oe && irq_out == $past(irq_act)))
        else $error("cmos pin does not follow pending events");
    eof_needs_arm_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        valid_bit[0] |=> (armed_q[0] && gap_q[0] == 3'h0)) else $error("valid bit did not arm gap count");
    eof_flag_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        eof_ev[0] |=> eof_q[0]) else $error("end of frame flag not set");
    underflow_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_data_c[0] && !dfull_q[0]) |=> under_q[0]) else $error("underflow not flagged");
    overflow_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (pop_c[0] && dfull_q[0] && !rd_data_c[0]) |=> over_q[0]) else $error("overflow not flagged");
    full_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        pop_c[0] |=> (full_q[0] && dfull_q[0])) else $error("full not flagged on load");
    status_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !rx_mode |-> (status_byte == 8'h00 && !irq_act)) else $error("status visible outside receive mode");
    serial_path_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!byte_mode_q && rx_bit_strobe[0]) |=> serial_data_valid_pin == $past(rx_bit_valid[0] && rx_mode))
        else $error("bit-serial valid pin wrong");
endmodule

// ### design/rbirq_regs.svh
// Register offsets, field positions, reset values and timing for the receive interrupt block
`ifndef RBIRQ_REGS_SVH
`define RBIRQ_REGS_SVH
`define RBIRQ_OFS_PIN_CFG     6'h05
`define RBIRQ_OFS_BYTE_CTL    6'h06
`define RBIRQ_OFS_IRQ_EN      6'h07
`define RBIRQ_OFS_STATUS      6'h08
`define RBIRQ_OFS_DATA_A      6'h09
`define RBIRQ_OFS_DATA_B      6'h0B
`define RBIRQ_RST_PIN_CFG     2'h1
`define RBIRQ_RST_BYTE_MODE   1'h0
`define RBIRQ_RST_EOF_LEN     3'h3
`define RBIRQ_RST_IRQ_EN      8'h00
`define RBIRQ_BIT_BYTE_MODE   3
`define RBIRQ_BIT_SPI_WRITE   7
`define RBIRQ_PIN_OPEN_SRC    2'h3
`define RBIRQ_PIN_OPEN_DRN    2'h2
`define RBIRQ_PIN_CMOS        2'h1
`define RBIRQ_PIN_CMOS_INV    2'h0
`define RBIRQ_SYNC_STAGES     2
`endif

// ### design/rbirq_pkg.sv
// Types shared by the receive interrupt block
package rbirq_pkg;
    typedef struct packed {
        logic       chan;
        logic       all_valid;
        logic [7:0] data;
    } rbirq_word_type;

    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_ADDR,
        SPI_DATA,
        SPI_DONE
    } rbirq_spi_state_type;
endpackage

// ### testbench/rbirq_host_model.sv
// Host side model: serial register master for the receive interrupt block
`timescale 1ns/1ps

module rbirq_host_model (
    input  wire logic clk_sys,
    output logic      spi_ss_n,
    output logic      spi_sck,
    output logic      spi_mosi,
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe
);
    initial begin
        spi_ss_n = 1'b1;
        spi_sck  = 1'b0;
        spi_mosi = 1'b0;
    end

    // Address byte then data byte, MSB first, 160 ns serial clock
    task automatic xfer(input logic wr, input logic [5:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] sh;
        sh = {wr, 1'b0, addr, wdata};
        rdata = 8'h00;
        @(negedge clk_sys);
        spi_ss_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = sh[i];
            repeat (8) @(negedge clk_sys);
            spi_sck = 1'b1;
            repeat (8) @(negedge clk_sys);
            // Read bit stands from the address byte's last rise, then from fall to fall
            if (i >= 1 && i <= 8) begin
                rdata = {rdata[6:0], spi_miso & spi_miso_oe};
            end
            spi_sck = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        spi_ss_n = 1'b1;
        // Line no longer meaningful once deselected
        spi_mosi = ~spi_mosi;
        repeat (6) @(negedge clk_sys);
    endtask

    // Register write with reserved bits forced to zero
    task automatic cfg_write(input logic [5:0] addr, input logic [7:0] data);
        logic [7:0] dummy;
        case (addr)
            6'h05: data = data & 8'h03;
            6'h06: data = data & 8'h0F;
            default: data = data;
        endcase
        xfer(1'b1, addr, data, dummy);
    endtask
endmodule

// ### testbench/rbirq_top_tb.sv
// Self-checking bench for the receive interrupt block
`timescale 1ns/1ps

module rbirq_top_tb;
    logic       clk_sys;
    logic       resetn;
    logic       spi_ss_n;
    logic       spi_sck;
    logic       spi_mosi;
    logic       spi_miso;
    logic       spi_miso_oe;
    logic       rx_mode;
    logic [1:0] rx_bit_strobe;
    logic [1:0] rx_bit_valid;
    logic [1:0] rx_bit_value;
    logic       irq_out;
    logic       irq_oe;
    logic       serial_data_pin;
    logic       serial_data_valid_pin;
    logic [7:0] d;
    int         mismatches;
    int         cmp_count;

    rbirq_top #(.FIFO_DEPTH(4)) rbirq_top_inst (
        .clk_sys               (clk_sys),
        .resetn                (resetn),
        .spi_ss_n              (spi_ss_n),
        .spi_sck               (spi_sck),
        .spi_mosi              (spi_mosi),
        .spi_miso              (spi_miso),
        .spi_miso_oe           (spi_miso_oe),
        .rx_mode               (rx_mode),
        .rx_bit_strobe         (rx_bit_strobe),
        .rx_bit_valid          (rx_bit_valid),
        .rx_bit_value          (rx_bit_value),
        .irq_out               (irq_out),
        .irq_oe                (irq_oe),
        .serial_data_pin       (serial_data_pin),
        .serial_data_valid_pin (serial_data_valid_pin)
    );

    rbirq_host_model rbirq_host_model_inst (
        .clk_sys     (clk_sys),
        .spi_ss_n    (spi_ss_n),
        .spi_sck     (spi_sck),
        .spi_mosi    (spi_mosi),
        .spi_miso    (spi_miso),
        .spi_miso_oe (spi_miso_oe)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        rbirq_host_model_inst.xfer(1'b0, a, 8'h00, v);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        rbirq_host_model_inst.cfg_write(a, v);
    endtask

    // One bit time on a receive channel
    task automatic rx_bit(input int ch, input logic v, input logic b);
        @(negedge clk_sys);
        rx_bit_strobe[ch] = 1'b1;
        rx_bit_valid[ch] = v;
        rx_bit_value[ch] = b;
        @(negedge clk_sys);
        rx_bit_strobe[ch] = 1'b0;
        rx_bit_value[ch] = ~b;
        repeat (3) @(negedge clk_sys);
    endtask

    task automatic send_byte(input int ch, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            rx_bit(ch, 1'b1, b[i]);
        end
    endtask

    // Flush assembly and gap state, then clear flags
    task automatic clean;
        logic [7:0] v;
        rx_mode = 1'b0;
        repeat (2) @(negedge clk_sys);
        rx_mode = 1'b1;
        rd(6'h08, v);
    endtask

    task automatic pin_chk(input logic [1:0] code, input logic act);
        logic exp_out;
        logic exp_oe;
        exp_out = code[1] ? code[0] : (code[0] ? act : ~act);
        exp_oe  = code[1] ? act : 1'b1;
        chk("irq pin oe,out", {6'h00, exp_oe, exp_out}, {6'h00, irq_oe, irq_out});
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        mismatches++;
        end_of_test();
    end

    initial begin
        resetn = 1'b0;
        rx_mode = 1'b0;
        rx_bit_strobe = 2'h0;
        rx_bit_valid = 2'h0;
        rx_bit_value = 2'h0;
        repeat (10) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
        pin_chk(2'h1, 1'b0);
        rd(6'h05, d);
        chk("pin config", 8'h01, d);
        rd(6'h06, d);
        chk("byte mode control", 8'h03, d);
        rd(6'h07, d);
        chk("irq enable", 8'h00, d);
        rd(6'h3F, d);
        chk("unmapped", 8'h00, d);
        wr(6'h07, 8'hA5);
        rd(6'h07, d);
        chk("irq enable", 8'hA5, d);
        wr(6'h07, 8'h00);
        rx_mode = 1'b1;
        // Bit-serial exchange on the serial pins
        rx_bit(0, 1'b1, 1'b1);
        chk("serial pins", 8'h03, {6'h00, serial_data_valid_pin, serial_data_pin});
        rx_bit(0, 1'b1, 1'b0);
        chk("serial pins", 8'h02, {6'h00, serial_data_valid_pin, serial_data_pin});
        // Byte mode, gap length zero
        wr(6'h06, 8'h08);
        clean();
        send_byte(0, 8'hA5);
        rd(6'h08, d);
        chk("status full", 8'h09, d);
        rd(6'h09, d);
        rd(6'h09, d);
        rd(6'h08, d);
        chk("status underflow", 8'h04, d & 8'h77);
        for (int i = 0; i < 3; i++) begin
            rx_bit(0, 1'b1, 1'b1);
        end
        rx_bit(0, 1'b0, 1'b0);
        rd(6'h08, d);
        chk("status partial eof", 8'h03, d);
        send_byte(0, 8'h3C);
        rd(6'h08, d);
        chk("status overflow", 8'h0D, d);
        // Gap length two on channel B
        wr(6'h06, 8'h0A);
        clean();
        for (int i = 0; i < 4; i++) begin
            rx_bit(1, 1'b0, 1'b0);
        end
        rd(6'h08, d);
        chk("status unarmed", 8'h08, d);
        send_byte(1, 8'h5A);
        rx_bit(1, 1'b0, 1'b0);
        rx_bit(1, 1'b0, 1'b0);
        rd(6'h08, d);
        chk("status gap short", 8'h98, d);
        rx_bit(1, 1'b0, 1'b0);
        rd(6'h08, d);
        chk("status eof B", 8'h20, d & 8'h20);
        // Every pin drive code, assert then clear by status read
        wr(6'h06, 8'h08);
        wr(6'h07, 8'h02);
        for (int c = 0; c < 4; c++) begin
            wr(6'h05, 8'(c));
            rx_bit(0, 1'b1, 1'b1);
            rx_bit(0, 1'b0, 1'b0);
            pin_chk(2'(c), 1'b1);
            rd(6'h08, d);
            pin_chk(2'(c), 1'b0);
        end
        wr(6'h05, 8'h01);
        wr(6'h07, 8'h00);
        rx_bit(0, 1'b1, 1'b1);
        rx_bit(0, 1'b0, 1'b0);
        pin_chk(2'h1, 1'b0);
        rd(6'h08, d);
        chk("status polled eof", 8'h02, d & 8'h02);
        wr(6'h07, 8'h02);
        rx_bit(0, 1'b1, 1'b1);
        rx_bit(0, 1'b0, 1'b0);
        rx_mode = 1'b0;
        repeat (2) @(negedge clk_sys);
        rd(6'h08, d);
        chk("status outside receive", 8'h00, d);
        pin_chk(2'h1, 1'b0);
        end_of_test();
    end
endmodule
